// *** core/hmc_pkg.sv ***
/*
 * Shared constants and types for the standby (HALT) controller.
 * Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus.
 */
package hmc_pkg;

    // ------------------------------------------------------------
    // Wake timing, in CPU clocks
    // ------------------------------------------------------------
    localparam int unsigned WAKE_VEC_CLKS = 8;  // Vectored wake wait
    localparam int unsigned WAKE_SEQ_CLKS = 2;  // Sequential wake wait
    localparam int unsigned WCNT_W        = 4;  // Wait counter width
    localparam logic [WCNT_W-1:0] WAKE_VEC_LOAD = WCNT_W'(WAKE_VEC_CLKS - 1);
    localparam logic [WCNT_W-1:0] WAKE_SEQ_LOAD = WCNT_W'(WAKE_SEQ_CLKS - 1);
    localparam logic [WCNT_W-1:0] WCNT_ZERO     = 4'h0;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned IRQ_W  = 8;   // Interrupt request lines
    localparam int unsigned PORT_W = 8;   // Port latch width
    localparam int unsigned ADR_W  = 4;   // Byte address width
    localparam int unsigned DAT_W  = 32;  // Bus data width
    localparam int unsigned SEL_W  = 4;   // Byte selects

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [ADR_W-1:0] CTRL_ADDR = 4'h0;  // Control, R/W
    localparam logic [ADR_W-1:0] STAT_ADDR = 4'h4;  // Status, R/O
    localparam int unsigned CTRL_STOPPABLE_BIT = 0; // Low osc may be stopped
    localparam int unsigned CTRL_STOPREQ_BIT   = 1; // Stop low osc request
    localparam int unsigned STAT_HALT_BIT      = 0; // In HALT or waking
    localparam int unsigned STAT_LOWSRC_BIT    = 1; // Entered from low osc
    localparam int unsigned STAT_VECT_BIT      = 2; // Last wake vectored
    localparam int unsigned STAT_OSCOFF_BIT    = 3; // Low osc stopped
    localparam logic CTRL_STOPPABLE_RST = 1'b0;
    localparam logic CTRL_STOPREQ_RST   = 1'b0;
    localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_WAKE} hmc_state_type;

    // Bus request from the master
    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [SEL_W-1:0] sel;
        logic [ADR_W-1:0] adr;
        logic [DAT_W-1:0] dat;
    } hmc_wb_req_type;

    // Count and clock source selections of peripherals
    typedef struct packed {
        logic timerAFromPin;    // First timer counts its event pin
        logic timerBFromDiv128; // Second timer runs on low osc / 2^7
        logic serialFromTimerA; // Serial clock is first timer output
        logic timerARunning;    // First timer is counting
    } hmc_src_type;

    // Run enables to peripherals
    typedef struct packed {
        logic inverterTimer;
        logic timer16;
        logic timerA;
        logic timerB;
        logic serial;
        logic watchdog;
        logic realTimeOut;
        logic adc;
        logic mulDiv;
        logic alwaysOn;         // Reset monitors, ext irq, Hi-Z control
    } hmc_periph_type;

    localparam hmc_periph_type PERIPH_ALL = 10'h3ff;

endpackage

// *** core/hmc_halt_ctrl.sv ***
/*
 * HALT standby controller: gates the CPU clock, freezes port
 * latches, steers peripheral run enables and times the wake-up.
 * Assumes the CPU core pulses haltExec and the interrupt controller
 * presents request and mask lines synchronous to sys_clk.
 */
module hmc_halt_ctrl
    import hmc_pkg::*;
(
    input  wire logic             sys_clk,        // System clock
    input  wire logic             reset_n,        // Async reset, low
    input  wire hmc_wb_req_type   wbReq,          // Bus request
    output logic                  wbAck,          // Bus acknowledge
    output logic [DAT_W-1:0]      wbDatOut,       // Bus read data
    input  wire logic             haltExec,       // Halt executed, pulse
    input  wire logic             cpuOnLowSpeed,  // CPU runs on low osc
    input  wire logic [IRQ_W-1:0] irqReq,         // Request flags
    input  wire logic [IRQ_W-1:0] irqMask,        // Mask flags, 1 masks
    input  wire logic             intAckEnable,   // Acknowledge enabled
    input  wire hmc_src_type      periphSrc,      // Peripheral sources
    input  wire logic [PORT_W-1:0] portLatchIn,   // Live latch values
    output logic [PORT_W-1:0]     portOut,        // Held latch values
    output logic                  cpuClockEnable, // CPU clock gate
    output logic                  haltActive,     // In HALT or waking
    output logic                  wakeVector,     // Take vector, pulse
    output logic                  wakeResume,     // Next instr, pulse
    output logic                  resetVectorStart, // Boot, pulse
    output logic                  lowOscStop,     // Stop low osc
    output hmc_periph_type        periphEnable    // Peripheral enables
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rstMeta;                  // First stage, read by rstN only
    logic rstN;                     // Released reset
    logic bootDone;                 // First cycle after release seen

    // Assert asynchronously, release through two flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    // One pulse after release starts fetch from the reset vector
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            bootDone         <= 1'b0;
            resetVectorStart <= 1'b0;
        end else begin
            bootDone         <= 1'b1;
            resetVectorStart <= !bootDone;
        end
    end

    // ------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------
    logic ctrlStoppable;            // Low osc may be stopped
    logic ctrlStopReq;              // Software asks low osc to stop
    logic wbHit;                    // New request this cycle
    logic lowSrc;                   // HALT entered from low osc
    logic lastVectored;             // Last wake took the vector
    hmc_state_type state;           // Controller state

    // Ack one cycle after the strobe; dropped the cycle after
    assign wbHit = wbReq.cyc && wbReq.stb && !wbAck;

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= wbHit;
        end
    end

    // Control writes land at the ack edge, while the master still holds them;
    // only byte lane 0 carries the bits
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            ctrlStoppable <= CTRL_STOPPABLE_RST;
            ctrlStopReq   <= CTRL_STOPREQ_RST;
        end else if (wbReq.cyc && wbReq.stb && wbAck && wbReq.we && wbReq.sel[0]) begin
            if (wbReq.adr == CTRL_ADDR) begin
                ctrlStoppable <= wbReq.dat[CTRL_STOPPABLE_BIT];
                ctrlStopReq   <= wbReq.dat[CTRL_STOPREQ_BIT];
            end
        end
    end

    // Read data; unmapped addresses read zero and ignore writes
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            wbDatOut <= DAT_ZERO;
        end else if (wbHit && !wbReq.we) begin
            wbDatOut <= DAT_ZERO;
            if (wbReq.adr == CTRL_ADDR) begin
                wbDatOut[CTRL_STOPPABLE_BIT] <= ctrlStoppable;
                wbDatOut[CTRL_STOPREQ_BIT]   <= ctrlStopReq;
            end else if (wbReq.adr == STAT_ADDR) begin
                wbDatOut[STAT_HALT_BIT]   <= state != ST_RUN;
                wbDatOut[STAT_LOWSRC_BIT] <= lowSrc;
                wbDatOut[STAT_VECT_BIT]   <= lastVectored;
                wbDatOut[STAT_OSCOFF_BIT] <= lowOscStop;
            end
        end
    end

    // Stop request only counts when the option allows stopping
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            lowOscStop <= 1'b0;
        end else begin
            lowOscStop <= ctrlStoppable && ctrlStopReq;
        end
    end

    // ------------------------------------------------------------
    // HALT state machine
    // ------------------------------------------------------------
    logic              wakeReq;     // Any unmasked request
    logic              takeVector;  // Wake will take the vector
    logic [WCNT_W-1:0] waitCnt;     // Wake wait countdown

    assign wakeReq = |(irqReq & ~irqMask);

    // Entry, wake and countdown; reset drops straight to run
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            state      <= ST_RUN;
            lowSrc     <= 1'b0;
            takeVector <= 1'b0;
            waitCnt    <= WCNT_ZERO;
        end else begin
            case (state)
                ST_RUN: begin
                    // Either clock source may enter HALT
                    if (haltExec) begin
                        state  <= ST_HALT;
                        lowSrc <= cpuOnLowSpeed;
                    end
                end
                ST_HALT: begin
                    // Acknowledge enable picks the wake path
                    if (wakeReq) begin
                        state      <= ST_WAKE;
                        takeVector <= intAckEnable;
                        waitCnt    <= intAckEnable ? WAKE_VEC_LOAD
                                                   : WAKE_SEQ_LOAD;
                    end
                end
                ST_WAKE: begin
                    // Count the fixed wait out before resuming
                    if (waitCnt == WCNT_ZERO) begin
                        state <= ST_RUN;
                    end else begin
                        waitCnt <= waitCnt - 1'b1;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    logic waitDone;                 // Last cycle of the wake wait
    assign waitDone = (state == ST_WAKE) && (waitCnt == WCNT_ZERO);

    // Wake pulses and the record of the path taken
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            wakeVector   <= 1'b0;
            wakeResume   <= 1'b0;
            lastVectored <= 1'b0;
        end else begin
            wakeVector <= waitDone && takeVector;
            wakeResume <= waitDone && !takeVector;
            if (waitDone) begin
                lastVectored <= takeVector;
            end
        end
    end

    // ------------------------------------------------------------
    // CPU clock gate and port latches
    // ------------------------------------------------------------
    logic [PORT_W-1:0] next_portOut;  // Follows live value in run

    // Clock stops from the entry edge until the wait is over
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            cpuClockEnable <= 1'b1;
            haltActive     <= 1'b0;
        end else begin
            cpuClockEnable <= (state == ST_RUN && !haltExec) || waitDone;
            haltActive     <= (state == ST_RUN) ? haltExec : !waitDone;
        end
    end

    // Hold the value present at entry; no write reaches it in HALT
    assign next_portOut = (state == ST_RUN && !haltExec) ? portLatchIn : portOut;

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            portOut <= '0;
        end else begin
            portOut <= next_portOut;
        end
    end

    // ------------------------------------------------------------
    // Peripheral run enables
    // ------------------------------------------------------------
    hmc_periph_type next_periph;    // Enables for the next cycle
    logic           inHalt;         // HALT or waking, or entering

    assign inHalt = (state != ST_RUN) || haltExec;

    // Low osc source limits what keeps its guarantee in HALT
    always_comb begin
        next_periph          = PERIPH_ALL;
        next_periph.alwaysOn = 1'b1;
        if (inHalt) begin
            // Watchdog halts when the low osc may be stopped
            next_periph.watchdog = !ctrlStoppable;
            if ((state == ST_RUN) ? cpuOnLowSpeed : lowSrc) begin
                next_periph.inverterTimer = 1'b0;
                next_periph.timer16       = 1'b0;
                next_periph.realTimeOut   = 1'b0;
                next_periph.adc           = 1'b0;
                next_periph.mulDiv        = 1'b0;
                next_periph.timerA = periphSrc.timerAFromPin;
                next_periph.timerB = periphSrc.timerBFromDiv128;
                next_periph.serial = periphSrc.serialFromTimerA
                                     && periphSrc.timerARunning;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            periphEnable <= PERIPH_ALL;
        end else begin
            periphEnable <= next_periph;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstN);

    sequence wakeVecSeq;
        state == ST_HALT && wakeReq && intAckEnable;
    endsequence

    sequence wakeSeqSeq;
        state == ST_HALT && wakeReq && !intAckEnable;
    endsequence

    halt_entry_a: assert property (state == ST_RUN && haltExec |=> state == ST_HALT)
        else $error("halt not entered");
    clock_gated_a: assert property (state == ST_HALT |-> ##1 !cpuClockEnable)
        else $error("cpu clock runs in halt");
    port_hold_a: assert property (state == ST_HALT |=> portOut == $past(portOut))
        else $error("port latch changed in halt");
    timer_a_gate_a: assert property (state == ST_HALT && lowSrc
        && !periphSrc.timerAFromPin |=> !periphEnable.timerA)
        else $error("first timer enabled off pin");
    timer_b_gate_a: assert property (state == ST_HALT && lowSrc
        && !periphSrc.timerBFromDiv128 |=> !periphEnable.timerB)
        else $error("second timer enabled off divider");
    serial_gate_a: assert property (state == ST_HALT && lowSrc
        && !periphSrc.timerARunning |=> !periphEnable.serial)
        else $error("serial enabled without timer clock");
    watchdog_stop_a: assert property (state == ST_HALT && ctrlStoppable
        |=> !periphEnable.watchdog)
        else $error("watchdog runs while stoppable");
    wake_exit_a: assert property (state == ST_HALT && wakeReq |=> state == ST_WAKE)
        else $error("unmasked request ignored");
    // Pulse is registered: seen one edge after the last wait cycle
    vector_wait_a: assert property (wakeVecSeq |-> ##9 wakeVector)
        else $error("vectored wake not at eight clocks");
    resume_wait_a: assert property (wakeSeqSeq |-> !wakeResume ##3 wakeResume)
        else $error("sequential wake not at two clocks");
    always_on_a: assert property (state == ST_HALT && !lowSrc
        |=> periphEnable.alwaysOn && periphEnable.timer16 && periphEnable.adc)
        else $error("peripheral disabled in high-speed halt");

endmodule

// *** bench/hmc_cpu_model.sv ***
/*
 * Model of the CPU core and interrupt controller beside the standby
 * controller: issues halt, raises and masks wake requests.
 * Assumes all lines are sampled on the rising edge of sys_clk.
 */
module hmc_cpu_model
    import hmc_pkg::*;
(
    input  wire logic        sys_clk,       // System clock
    input  wire logic        wakeVector,    // Vectored wake pulse
    input  wire logic        wakeResume,    // Sequential wake pulse
    output logic             haltExec,      // Halt executed
    output logic             cpuOnLowSpeed, // CPU clock source
    output logic [IRQ_W-1:0] irqReq,        // Request flags
    output logic [IRQ_W-1:0] irqMask,       // Mask flags
    output logic             intAckEnable   // Acknowledge enabled
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int NOP_WAIT = 85;  // No-op count sized for the fastest low osc

    // ----
    // Idle state: all requests masked
    // ----
    initial begin
        haltExec = 1'b0;
        cpuOnLowSpeed = 1'b0;
        irqReq = '0;
        irqMask = '1;
        intAckEnable = 1'b0;
    end

    // Halt instruction: one-cycle pulse, source sampled with it
    task automatic doHalt(input logic lowSrc);
        @(posedge sys_clk);
        haltExec <= 1'b1;
        cpuOnLowSpeed <= lowSrc;
        @(posedge sys_clk);
        haltExec <= 1'b0;
    endtask

    // Present requests, masks and acknowledge enable together
    task automatic setIrq(input logic [IRQ_W-1:0] req, input logic [IRQ_W-1:0] mask,
                          input logic ack);
        @(posedge sys_clk);
        irqReq <= req;
        irqMask <= mask;
        intAckEnable <= ack;
    endtask

    // Boot runs on the low osc; software waits out the start-up before
    // switching, unless the crystal input is an external clock
    task automatic bootClock(input logic extClock);
        @(posedge sys_clk);
        cpuOnLowSpeed <= 1'b1;
        if (!extClock) begin
            repeat (NOP_WAIT) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        cpuOnLowSpeed <= 1'b0;
    endtask

    // Hold an unmasked request until the wake pulse, count edges from launch
    task automatic wakeUp(input logic [IRQ_W-1:0] req, input logic [IRQ_W-1:0] mask,
                          input logic ack, output int n, output logic [1:0] seen);
        setIrq(req, mask, ack);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while ((wakeVector | wakeResume) !== 1'b1 && n < 40);
        // Captured while the one-cycle pulses still stand
        seen = {wakeVector, wakeResume};
        // Serviced: the request flag drops, as a real CPU would clear it
        @(posedge sys_clk);
        irqReq <= '0;
    endtask
endmodule

// *** bench/tb.sv ***
/*
 * Self-checking bench for the standby controller: bus accesses,
 * halt entry from both clock sources, wake timing and reset in halt.
 * Assumes the controller answers each bus request with a one-cycle ack.
 */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import hmc_pkg::*;

    logic           sys_clk = 1'b0;   // 100 MHz clock
    logic           reset_n = 1'b0;   // Active-low reset
    hmc_wb_req_type wbReq;            // Bus request
    logic           wbAck;            // Bus acknowledge
    logic [31:0]    wbDatOut;         // Read data
    logic           haltExec;         // From CPU model
    logic           cpuOnLowSpeed;    // From CPU model
    logic [7:0]     irqReq;           // From CPU model
    logic [7:0]     irqMask;          // From CPU model
    logic           intAckEnable;     // From CPU model
    hmc_src_type    periphSrc;        // Peripheral sources
    logic [7:0]     portLatchIn;      // Live port latches
    logic [7:0]     portOut;          // Held port latches
    logic           cpuClockEnable;   // CPU clock gate
    logic           haltActive;       // Halted or waking
    logic           wakeVector;       // Vectored wake pulse
    logic           wakeResume;       // Sequential wake pulse
    logic           resetVectorStart; // Boot pulse
    logic           lowOscStop;       // Low osc stop
    hmc_periph_type periphEnable;     // Peripheral enables
    int             errCount;         // Mismatches
    int             testsRun;         // Comparisons
    logic [31:0]    rd;               // Last read data
    int             n;                // Edge count
    logic [1:0]     seen;             // Wake pulses seen
    hmc_periph_type expP;             // Expected enables

    always #5 sys_clk = ~sys_clk;

    hmc_halt_ctrl hmc_halt_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n), .wbReq(wbReq),
        .wbAck(wbAck), .wbDatOut(wbDatOut), .haltExec(haltExec),
        .cpuOnLowSpeed(cpuOnLowSpeed), .irqReq(irqReq), .irqMask(irqMask),
        .intAckEnable(intAckEnable), .periphSrc(periphSrc), .portLatchIn(portLatchIn),
        .portOut(portOut), .cpuClockEnable(cpuClockEnable), .haltActive(haltActive),
        .wakeVector(wakeVector), .wakeResume(wakeResume),
        .resetVectorStart(resetVectorStart), .lowOscStop(lowOscStop),
        .periphEnable(periphEnable));

    hmc_cpu_model hmc_cpu_model_inst (.sys_clk(sys_clk), .wakeVector(wakeVector),
        .wakeResume(wakeResume), .haltExec(haltExec), .cpuOnLowSpeed(cpuOnLowSpeed),
        .irqReq(irqReq), .irqMask(irqMask), .intAckEnable(intAckEnable));

    // ----
    // Helpers
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        testsRun++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wbAccess(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        @(posedge sys_clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
        // Only the watchdog ends a wait that never sees ack
        do begin
            @(posedge sys_clk);
        end while (wbAck !== 1'b1);
        rd = wbDatOut;
        wbReq <= '0;
    endtask

    // Reset, check values while held, then time the boot pulse
    task automatic resetDut(input int cyc);
        int k;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        #1;
        check(32'(haltActive), 32'h0, "halt flag in reset");
        check(32'(cpuClockEnable), 32'h1, "clock gate in reset");
        check(32'(periphEnable), 32'(PERIPH_ALL), "enables in reset");
        repeat (cyc) @(posedge sys_clk);
        reset_n <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
        end while (resetVectorStart !== 1'b1 && k < 10);
        check(32'(k), 32'h3, "boot pulse delay");
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        errCount++;
        $display("unexpected at %0t: run did not complete", $time);
        finish_test();
    end

    // ----
    // Main sequence
    // ----
    initial begin
        wbReq = '0;
        periphSrc = '0;
        portLatchIn = 8'h00;
        errCount = 0;
        testsRun = 0;
        resetDut(20);
        hmc_cpu_model_inst.bootClock(1'b0);
        $display("test reset done");

        // Registers: stoppable low osc with stop request, unmapped place
        wbAccess(1'b1, CTRL_ADDR, 32'h3);
        wbAccess(1'b0, CTRL_ADDR, 32'h0);
        check(rd & 32'h3, 32'h3, "control readback");
        check(32'(lowOscStop), 32'h1, "low osc stopped");
        wbAccess(1'b1, 4'h8, 32'hf);
        wbAccess(1'b0, 4'h8, 32'h0);
        check(rd, 32'h0, "unmapped read");
        $display("test registers done");

        // High-speed halt: masked request must not wake, then vectored
        @(posedge sys_clk);
        portLatchIn <= 8'h5a;
        hmc_cpu_model_inst.doHalt(1'b0);
        #1;
        check(32'(cpuClockEnable), 32'h0, "clock gated");
        check(32'(haltActive), 32'h1, "halt entered");
        expP = PERIPH_ALL;
        expP.watchdog = 1'b0;  // Stoppable low osc stops the watchdog
        check(32'(periphEnable), 32'(expP), "high-speed enables");
        @(posedge sys_clk);
        portLatchIn <= 8'ha5;
        hmc_cpu_model_inst.setIrq(8'h01, 8'h01, 1'b1);
        repeat (12) @(posedge sys_clk);
        #1;
        check(32'(haltActive), 32'h1, "masked request held");
        check(32'(portOut), 32'h5a, "latch held");
        hmc_cpu_model_inst.wakeUp(8'h01, 8'h00, 1'b1, n, seen);
        #1;
        // Edges counted include the one at which the controller samples the request
        check(32'(n - 1), WAKE_VEC_CLKS, "vectored wake delay");
        check(32'(seen), 32'h2, "vector taken");
        check(32'(cpuClockEnable), 32'h1, "clock back");
        check(32'(portOut), 32'ha5, "latch follows again");
        $display("test high-speed halt done");

        // Low-speed halts, two source settings, both wake kinds
        wbAccess(1'b1, CTRL_ADDR, 32'h0);
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            periphSrc <= (i == 0) ? 4'b1010 : 4'b0111;
            hmc_cpu_model_inst.doHalt(1'b1);
            #1;
            expP = '0;
            expP.alwaysOn = 1'b1;
            expP.watchdog = 1'b1;  // Low osc cannot be stopped
            expP.timerA = periphSrc.timerAFromPin;
            expP.timerB = periphSrc.timerBFromDiv128;
            expP.serial = periphSrc.serialFromTimerA & periphSrc.timerARunning;
            check(32'(periphEnable), 32'(expP), "low-speed enables");
            wbAccess(1'b0, STAT_ADDR, 32'h0);
            // Last wake was vectored only before the first pass; low osc runs
            check(rd & 32'hf, (i == 0) ? 32'h7 : 32'h3, "status in halt");
            hmc_cpu_model_inst.wakeUp(8'h80, 8'h7f, i[0], n, seen);
            // Edges counted include the one at which the controller samples the request
            check(32'(n - 1), i ? WAKE_VEC_CLKS : WAKE_SEQ_CLKS, "wake delay");
            check(32'(seen), i ? 32'h2 : 32'h1, "wake kind");
            repeat (2) @(posedge sys_clk);
            #1;
            check(32'(periphEnable), 32'(PERIPH_ALL), "enables after wake");
        end
        $display("test low-speed halt done");

        // Reset while halted ends the halt and boots again
        hmc_cpu_model_inst.doHalt(1'b0);
        resetDut(4);
        hmc_cpu_model_inst.bootClock(1'b1);
        $display("test reset in halt done");
        finish_test();
    end
endmodule
